//--- logic/sfpf_fifo.sv
// Synchronous 9-bit FIFO with programmable almost flags and an AXI4-Lite status slave.
// Behaviour
// - Nine-bit word in and out; depth set by a power of two from 64 to 8K.
// - Dual-enable mode stores a word when enable A is low and the dual pin high.
// - Held enables store one word on every clock with no idle cycles.
// - Writes are ignored while the full flag is low.
// - Dual pin sampled at reset picks second write enable or offset-load control.
// - Flag mode stores a word when enable A is low, not loading, and not full.
// - Load control low makes write edges fill the flag-offset register instead.
// - Load control low makes read edges output the flag-offset register instead.
// - Both read enables low and not empty outputs the oldest word and removes it.
// - Empty flag is low whenever nothing is stored, updated on the read clock.
// - Full flag is low whenever the buffer is full, updated on the write clock.
// - Almost-empty goes low when the count is at or below its offset.
// - Almost-full goes low when free space is at or below its offset.
// - After reset both offsets are seven words.
// - Offsets are settable in single-word steps.
// - Empty and almost-empty change only on read clock edges.
// - Full and almost-full change only on write clock edges.
// - Every flag holds a new value for at least one clock.
// - Reset empties the buffer and sets the flags to match.
// - Output enable low drives the data outputs; high releases them.
// - Read and write may happen in the same cycle on the shared clock.
`default_nettype none
module sfpf_fifo #(
    parameter int ADDR_W = sfpf_pkg::DEPTH_LOG2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [8:0] wr_word,
    input wire logic wr_en_a_n,
    input wire logic wr_en_b_or_load_n,
    input wire logic rd_en_a_n,
    input wire logic rd_en_b_n,
    input wire logic output_enable_n,
    output logic [8:0] rd_word,
    output logic rd_word_oe,
    output logic empty_n,
    output logic full_n,
    output logic almost_empty_n,
    output logic almost_full_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [ADDR_W:0] DEPTH_CNT = (ADDR_W + 1)'(1 << ADDR_W);

    typedef struct packed {
        logic dual_mode;
        logic [ADDR_W-1:0] wptr;
        logic [ADDR_W-1:0] rptr;
        logic [ADDR_W:0] count;
        logic [8:0] rd_word;
        logic [8:0] ae_off;
        logic [8:0] af_off;
        logic ld_sel;
        logic rd_sel;
        logic empty_n;
        logic full_n;
        logic almost_empty_n;
        logic almost_full_n;
        logic flush;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sfpf_state_s;

    sfpf_state_s st;
    sfpf_state_s next_st;
    logic [8:0] mem [1 << ADDR_W];
    logic [8:0] mem_q;
    logic loading;
    logic wr_req;
    logic wr_fire;
    logic rd_req;
    logic rd_fire;
    logic ld_wr;
    logic ld_rd;

    // Both thresholds compare in a common width so any depth fits an offset.
    function automatic logic sfpf_at_or_below(input logic [ADDR_W:0] lvl, input logic [8:0] off);
        return 16'(lvl) <= 16'(off);
    endfunction

    function automatic logic sfpf_hit(input logic [7:0] addr, input logic [7:0] offset);
        return addr[7:2] == offset[7:2];
    endfunction

    function automatic logic [31:0] sfpf_read_reg(input sfpf_state_s s, input logic [7:0] addr);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (sfpf_hit(addr, sfpf_pkg::STATUS_OFFSET)) begin
            v[sfpf_pkg::STATUS_EMPTY_BIT] = s.empty_n;
            v[sfpf_pkg::STATUS_FULL_BIT] = s.full_n;
            v[sfpf_pkg::STATUS_AE_BIT] = s.almost_empty_n;
            v[sfpf_pkg::STATUS_AF_BIT] = s.almost_full_n;
            v[sfpf_pkg::STATUS_DUAL_BIT] = s.dual_mode;
        end else if (sfpf_hit(addr, sfpf_pkg::LEVEL_OFFSET)) begin
            v[ADDR_W:0] = s.count;
        end else if (sfpf_hit(addr, sfpf_pkg::OFFSETS_OFFSET)) begin
            v[8:0] = s.ae_off;
            v[sfpf_pkg::OFFSETS_AF_POS +: 9] = s.af_off;
        end
        return v;
    endfunction

    function automatic logic sfpf_mapped(input logic [7:0] addr);
        return sfpf_hit(addr, sfpf_pkg::CTRL_OFFSET) || sfpf_hit(addr, sfpf_pkg::STATUS_OFFSET)
            || sfpf_hit(addr, sfpf_pkg::LEVEL_OFFSET) || sfpf_hit(addr, sfpf_pkg::OFFSETS_OFFSET);
    endfunction

    assign mem_q = mem[st.rptr];
    assign loading = !st.dual_mode && !wr_en_b_or_load_n;
    assign wr_req = !wr_en_a_n && wr_en_b_or_load_n;
    assign wr_fire = wr_req && st.full_n;
    assign rd_req = !rd_en_a_n && !rd_en_b_n;
    assign rd_fire = rd_req && st.empty_n && !loading;
    assign ld_wr = loading && !wr_en_a_n;
    assign ld_rd = loading && rd_req;

    always_comb begin
        next_st = st;
        next_st.flush = 1'b0;
        if (wr_fire) begin
            next_st.wptr = st.wptr + 1'b1;
        end
        if (rd_fire) begin
            next_st.rptr = st.rptr + 1'b1;
            next_st.rd_word = mem_q;
        end
        // A push and a pop on the same edge cancel, so the level stays put.
        if (wr_fire && !rd_fire) begin
            next_st.count = st.count + 1'b1;
        end else if (rd_fire && !wr_fire) begin
            next_st.count = st.count - 1'b1;
        end
        if (ld_wr) begin
            if (st.ld_sel) begin
                next_st.af_off = wr_word;
            end else begin
                next_st.ae_off = wr_word;
            end
            next_st.ld_sel = !st.ld_sel;
        end
        if (ld_rd) begin
            next_st.rd_word = st.rd_sel ? st.af_off : st.ae_off;
            next_st.rd_sel = !st.rd_sel;
        end
        if (st.flush) begin
            next_st.wptr = '0;
            next_st.rptr = '0;
            next_st.count = '0;
        end
        // Flags come from the next level so they move on the same edge as the pointers.
        next_st.empty_n = next_st.count != '0;
        next_st.full_n = next_st.count != DEPTH_CNT;
        next_st.almost_empty_n = !sfpf_at_or_below(next_st.count, next_st.ae_off);
        next_st.almost_full_n = !sfpf_at_or_below(DEPTH_CNT - next_st.count, next_st.af_off);
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_got = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_got = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.aw_got && st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = sfpf_mapped(st.aw_addr) ? sfpf_pkg::RESP_OKAY : sfpf_pkg::RESP_SLVERR;
            if (sfpf_hit(st.aw_addr, sfpf_pkg::CTRL_OFFSET) && st.w_strb[0]) begin
                next_st.flush = st.w_data[sfpf_pkg::CTRL_FLUSH_BIT];
            end
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = sfpf_read_reg(st, s_axi_araddr);
            next_st.rresp = sfpf_mapped(s_axi_araddr) ? sfpf_pkg::RESP_OKAY : sfpf_pkg::RESP_SLVERR;
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (!aresetn) begin
            next_st = '0;
            // The reset is synchronous, so the strap is simply caught on each reset edge.
            next_st.dual_mode = wr_en_b_or_load_n;
            next_st.ae_off = sfpf_pkg::OFFSET_RESET;
            next_st.af_off = sfpf_pkg::OFFSET_RESET;
            next_st.almost_empty_n = 1'b0;
            next_st.almost_full_n = 1'b1;
            next_st.full_n = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        st <= next_st;
    end

    // Storage is not cleared; an empty pointer pair makes old words unreachable.
    always_ff @(posedge aclk) begin
        if (wr_fire && aresetn) begin
            mem[st.wptr] <= wr_word;
        end
    end

    assign rd_word = st.rd_word;
    assign rd_word_oe = !output_enable_n;
    assign empty_n = st.empty_n;
    assign full_n = st.full_n;
    assign almost_empty_n = st.almost_empty_n;
    assign almost_full_n = st.almost_full_n;
    assign s_axi_awready = !st.aw_got && !st.bvalid;
    assign s_axi_wready = !st.w_got && !st.bvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence seq_push_only;
        wr_fire && !rd_fire && !st.flush;
    endsequence

    sequence seq_pop_only;
        rd_fire && !wr_fire && !st.flush;
    endsequence

    a_push_counts: assert property (seq_push_only |=> st.count == $past(st.count) + 1'b1)
        else $error("Accepted write did not raise the level by one.");
    a_full_blocks: assert property (!full_n && wr_req && !rd_fire |=> st.wptr == $past(st.wptr))
        else $error("Write pointer moved while full.");
    a_pop_oldest: assert property (rd_fire |=> rd_word == $past(mem_q))
        else $error("Read did not present the oldest word.");
    a_last_pop_empty: assert property (seq_pop_only ##0 st.count == 1 |=> !empty_n)
        else $error("Empty flag not low after last word left.");
    a_fill_full: assert property (seq_push_only ##0 st.count == DEPTH_CNT - 1'b1 |=> !full_n)
        else $error("Full flag not low after last free slot filled.");
    a_ae_level: assert property (st.count <= 16'(st.ae_off) |-> !almost_empty_n)
        else $error("Almost-empty flag high at or below its offset.");
    a_af_level: assert property (16'(DEPTH_CNT - st.count) <= 16'(st.af_off) |-> !almost_full_n)
        else $error("Almost-full flag high within its offset of full.");
    a_reset_state: assert property (disable iff (1'b0) !aresetn |=> !empty_n && st.count == '0
        && st.ae_off == sfpf_pkg::OFFSET_RESET && st.af_off == sfpf_pkg::OFFSET_RESET)
        else $error("Reset did not empty the buffer and restore the offsets.");
    a_load_pair: assert property (ld_wr && !st.ld_sel ##1 ld_wr |=>
        st.ae_off == $past(wr_word, 2) && st.af_off == $past(wr_word))
        else $error("Offset load order wrong.");
    a_load_holds: assert property (ld_wr || ld_rd |-> !wr_fire || st.dual_mode)
        else $error("Buffer written while loading offsets.");
    a_empty_still: assert property (!empty_n && rd_req |=> st.rptr == $past(st.rptr))
        else $error("Read pointer moved while empty.");
    a_oe_follow: assert property (rd_word_oe != output_enable_n)
        else $error("Output enable polarity wrong.");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped before taken.");

    // A push and a pop together must move both pointers and leave the level alone.
    sequence seq_both_move;
        wr_fire && rd_fire && !st.flush;
    endsequence

    a_both_level: assert property (seq_both_move |=> st.count == $past(st.count))
        else $error("Level moved on a simultaneous push and pop.");
    a_both_ptrs: assert property (seq_both_move |=> st.wptr == $past(st.wptr) + 1'b1
        && st.rptr == $past(st.rptr) + 1'b1)
        else $error("Pointers did not both advance on push and pop.");
    a_pop_counts: assert property (seq_pop_only |=> st.count == $past(st.count) - 1'b1)
        else $error("Accepted read did not lower the level by one.");
    a_level_bound: assert property (st.count <= DEPTH_CNT)
        else $error("Level beyond the storage depth.");

    // Flags must track the level exactly, since they are registered from the same next level as the count.
    a_empty_match: assert property (empty_n == (st.count != '0))
        else $error("Empty flag disagrees with the level.");
    a_full_match: assert property (full_n == (st.count != DEPTH_CNT))
        else $error("Full flag disagrees with the level.");
    a_ae_above: assert property (16'(st.count) > 16'(st.ae_off) |-> almost_empty_n)
        else $error("Almost-empty flag low above its offset.");
    a_af_above: assert property (16'(DEPTH_CNT - st.count) > 16'(st.af_off) |-> almost_full_n)
        else $error("Almost-full flag low with room beyond its offset.");

    // Entering empty needs a pop or a flush; leaving it needs a push.
    a_empty_enter: assert property ($fell(empty_n) |-> $past(rd_fire || st.flush))
        else $error("Empty flag fell without a read or flush.");
    a_empty_leave: assert property ($rose(empty_n) |-> $past(wr_fire))
        else $error("Empty flag rose without a write.");
    a_full_enter: assert property ($fell(full_n) |-> $past(wr_fire))
        else $error("Full flag fell without a write.");
    a_full_leave: assert property ($rose(full_n) |-> $past(rd_fire || st.flush))
        else $error("Full flag rose without a read or flush.");
    a_ae_cause: assert property ($changed(almost_empty_n)
        |-> $past(rd_fire || wr_fire || st.flush || ld_wr))
        else $error("Almost-empty flag moved with nothing to move it.");
    a_af_cause: assert property ($changed(almost_full_n)
        |-> $past(rd_fire || wr_fire || st.flush || ld_wr))
        else $error("Almost-full flag moved with nothing to move it.");

    // The strap is caught during reset and must not drift once running.
    a_mode_strap: assert property (disable iff (1'b0) !aresetn |=>
        st.dual_mode == $past(wr_en_b_or_load_n))
        else $error("Mode strap not captured during reset.");
    a_mode_kept: assert property (aresetn |=> $stable(st.dual_mode))
        else $error("Mode changed outside reset.");
    a_dual_gate: assert property (st.dual_mode && !wr_en_b_or_load_n |-> !wr_fire)
        else $error("Write taken with the second enable inactive.");
    a_flag_write: assert property (!st.dual_mode && !wr_en_a_n && wr_en_b_or_load_n
        && st.full_n |-> wr_fire)
        else $error("Flag-mode write not taken.");

    // Offset access must leave the buffer pointers alone.
    a_load_no_push: assert property (ld_wr |=> st.wptr == $past(st.wptr))
        else $error("Write pointer moved during an offset load.");
    a_load_ae: assert property (ld_wr && !st.ld_sel |=> st.ae_off == $past(wr_word))
        else $error("First offset load missed the almost-empty offset.");
    a_load_af: assert property (ld_wr && st.ld_sel |=> st.af_off == $past(wr_word))
        else $error("Second offset load missed the almost-full offset.");
    a_off_stable: assert property (!ld_wr |=> $stable(st.ae_off) && $stable(st.af_off))
        else $error("Offsets changed without a load.");
    a_offrd_ae: assert property (ld_rd && !st.rd_sel |=> rd_word == $past(st.ae_off))
        else $error("First offset read did not show the almost-empty offset.");
    a_offrd_af: assert property (ld_rd && st.rd_sel |=> rd_word == $past(st.af_off))
        else $error("Second offset read did not show the almost-full offset.");
    a_offrd_no_pop: assert property (ld_rd |=> st.rptr == $past(st.rptr))
        else $error("Read pointer moved during an offset read.");
    a_read_hold: assert property (!rd_fire && !ld_rd |=> $stable(rd_word))
        else $error("Output word changed without a read.");
    a_flush_empties: assert property (st.flush |=> st.count == '0 && !empty_n)
        else $error("Flush did not empty the buffer.");

    // Bus handshakes: one transaction at a time, answers held until taken.
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("Read answer dropped or changed before taken.");
    a_w_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write channels open while a response is pending.");
    a_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read address open while read data is pending.");
endmodule // sfpf_fifo
`default_nettype wire

//--- logic/sfpf_pkg.sv
// Constants shared by the programmable-flag FIFO and its register slave.
`default_nettype none
package sfpf_pkg;
    // Storage depth is two to this power; 6 to 13 give the 64 to 8K word variants.
    localparam int DEPTH_LOG2 = 6;
    localparam int WORD_W = 9;
    localparam int OFF_W = 9;
    localparam logic [8:0] OFFSET_RESET = 9'h007;
    localparam int AXI_AW = 8;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] LEVEL_OFFSET = 8'h08;
    localparam logic [7:0] OFFSETS_OFFSET = 8'h0C;
    localparam int CTRL_FLUSH_BIT = 0;
    localparam int STATUS_EMPTY_BIT = 0;
    localparam int STATUS_FULL_BIT = 1;
    localparam int STATUS_AE_BIT = 2;
    localparam int STATUS_AF_BIT = 3;
    localparam int STATUS_DUAL_BIT = 4;
    localparam int OFFSETS_AF_POS = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sfpf_pkg
`default_nettype wire

//--- sim/sfpf_producer.sv
// Producer model that feeds words into the FIFO write port on request.
`default_nettype none
module sfpf_producer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req,
    input wire logic [8:0] word,
    output var logic [8:0] wr_word,
    output var logic wr_en_a_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial wr_en_a_n = 1'b1;
    initial wr_word = 9'h000;
    // An idle data bus toggles, so a stale word can never pass for a fresh one.
    always @(posedge aclk) begin
        if (!aresetn) begin
            wr_en_a_n <= 1'b1;
            wr_word <= 9'h1FF;
        end else if (req) begin
            wr_en_a_n <= 1'b0;
            wr_word <= word;
        end else begin
            wr_en_a_n <= 1'b1;
            wr_word <= ~wr_word;
        end
    end
endmodule // sfpf_producer
`default_nettype wire

//--- sim/sync_fifo_prog_flags_bench.sv
// Self-checking bench for the programmable-flag FIFO and its status registers.
`default_nettype none
module sync_fifo_prog_flags_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic pin = 1'b1;
    logic rd_a_n = 1'b1;
    logic rd_b_n = 1'b1;
    logic oe_n = 1'b0;
    logic req = 1'b0;
    logic [8:0] word = 9'h000;
    logic [8:0] wr_word, rd_word, next_wr, next_rd;
    logic wr_en_a_n, rd_word_oe, empty_n, full_n, ae_n, af_n;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    int num_errors = 0;
    int samples_checked = 0;
    always #12.5 aclk = ~aclk;
    sfpf_producer i_prod (.aclk(aclk), .aresetn(aresetn), .req(req), .word(word),
        .wr_word(wr_word), .wr_en_a_n(wr_en_a_n));
    sfpf_fifo i_dut (.aclk(aclk), .aresetn(aresetn), .wr_word(wr_word),
        .wr_en_a_n(wr_en_a_n), .wr_en_b_or_load_n(pin), .rd_en_a_n(rd_a_n),
        .rd_en_b_n(rd_b_n), .output_enable_n(oe_n), .rd_word(rd_word),
        .rd_word_oe(rd_word_oe), .empty_n(empty_n), .full_n(full_n),
        .almost_empty_n(ae_n), .almost_full_n(af_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic fl(input logic [3:0] exp);
        check("flags", {28'h0, exp}, {28'h0, empty_n, full_n, ae_n, af_n});
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic rst(input logic mode);
        @(posedge aclk);
        aresetn <= 1'b0;
        pin <= mode;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        next_wr = 9'h000;
        next_rd = 9'h000;
        #1;
    endtask
    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            req <= 1'b1;
            word <= next_wr;
            next_wr = next_wr + 9'h001;
        end
        @(posedge aclk);
        req <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
    endtask
    // Enables stay low across the burst, so each edge must yield the next word.
    task automatic pull(input int n, input bit live);
        @(posedge aclk);
        rd_a_n <= 1'b0;
        rd_b_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            if (i == n - 1) begin
                rd_a_n <= 1'b1;
                rd_b_n <= 1'b1;
            end
            #1;
            if (live) next_rd = next_rd + 9'h001;
            check("rd_word", {23'h0, next_rd - 9'h001}, {23'h0, rd_word});
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                bready <= 1'b0;
                check("bresp", {30'h0, er}, {30'h0, bresp});
                break;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rready <= 1'b0;
                check("rdata", ed, rdata);
                check("rresp", {30'h0, er}, {30'h0, rresp});
                break;
            end
        end
    endtask
    initial begin
        rst(1'b1);
        fl(4'h5);
        axi_rd(sfpf_pkg::OFFSETS_OFFSET, 32'h0007_0007, sfpf_pkg::RESP_OKAY);
        push(7);
        fl(4'hD);
        push(1);
        fl(4'hF);
        push(48);
        fl(4'hF);
        push(1);
        fl(4'hE);
        push(7);
        fl(4'hA);
        push(1);
        next_wr = next_wr - 9'h001;
        fl(4'hA);
        axi_rd(sfpf_pkg::LEVEL_OFFSET, 32'h40, sfpf_pkg::RESP_OKAY);
        axi_rd(sfpf_pkg::STATUS_OFFSET, 32'h15, sfpf_pkg::RESP_OKAY);
        @(posedge aclk);
        oe_n <= 1'b1;
        @(posedge aclk);
        check("rd_word_oe", 32'h0, {31'h0, rd_word_oe});
        oe_n <= 1'b0;
        #1;
        check("rd_word_oe", 32'h1, {31'h0, rd_word_oe});
        pull(64, 1'b1);
        fl(4'h5);
        pull(1, 1'b0);
        fl(4'h5);
        push(10);
        fork
            push(4);
            pull(4, 1'b1);
        join
        axi_rd(sfpf_pkg::LEVEL_OFFSET, 32'h0A, sfpf_pkg::RESP_OKAY);
        axi_wr(sfpf_pkg::CTRL_OFFSET, 32'h1, sfpf_pkg::RESP_OKAY);
        repeat (2) @(posedge aclk);
        #1;
        fl(4'h5);
        axi_rd(sfpf_pkg::LEVEL_OFFSET, 32'h0, sfpf_pkg::RESP_OKAY);
        axi_rd(8'h10, 32'h0, sfpf_pkg::RESP_SLVERR);
        axi_wr(8'h10, 32'h1, sfpf_pkg::RESP_SLVERR);
        rst(1'b0);
        next_wr = 9'h003;
        push(2);
        fl(4'h5);
        axi_rd(sfpf_pkg::OFFSETS_OFFSET, 32'h0004_0003, sfpf_pkg::RESP_OKAY);
        next_rd = 9'h003;
        pull(2, 1'b1);
        @(posedge aclk);
        pin <= 1'b1;
        next_wr = 9'h020;
        push(3);
        fl(4'hD);
        push(1);
        fl(4'hF);
        axi_rd(sfpf_pkg::STATUS_OFFSET, 32'h0F, sfpf_pkg::RESP_OKAY);
        report_and_stop();
    end
    // The whole run needs well under a thousand cycles; five thousand marks a hang.
    initial begin
        #(25 * 5000);
        num_errors++;
        report_and_stop();
    end
endmodule // sync_fifo_prog_flags_bench
`default_nettype wire
